/* File: common/spbrg_pkg.sv */
`default_nettype none

// Shared constants of the serial port baud rate generator.
package spbrg_pkg;

   // Register bus geometry.
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;

   // Register indices on the plain register port.
   localparam logic [2:0] REG_RELOAD = 3'h0;
   localparam logic [2:0] REG_BUFFER = 3'h1;
   localparam logic [2:0] REG_CTRL = 3'h2;
   localparam logic [2:0] REG_STATUS = 3'h3;
   localparam logic [2:0] REG_COUNT = 3'h4;

   // Control register field positions.
   localparam int CTRL_EN = 0;
   localparam int CTRL_I2C = 1;
   localparam int CTRL_IDLE_HI = 2;
   localparam int CTRL_W = 3;

   // Status register field positions.
   localparam int STAT_BUSY = 0;
   localparam int STAT_LEVEL = 1;
   localparam int STAT_WCOL = 2;

   // Reset values.
   localparam logic [7:0] RELOAD_RST = 8'h00;
   localparam logic [7:0] BUFFER_RST = 8'h00;
   localparam logic [2:0] CTRL_RST = 3'h0;
   localparam logic [7:0] ZERO8 = 8'h00;

   // Half periods of one operation: eight clocks for a SPI byte,
   // nine for an I2C byte with its acknowledge.
   localparam logic [4:0] SPI_HALVES = 5'h10;
   localparam logic [4:0] I2C_HALVES = 5'h12;
   localparam logic [4:0] HALF_ONE = 5'h01;
   localparam logic [4:0] HALF_RST = 5'h00;

   // Oscillator periods in one full serial clock period per count
   // step, and hence clocks per down-counter step in a half period.
   localparam int OSC_PER_STEP = 4;
   localparam int CLKS_PER_STEP = OSC_PER_STEP / 2;
   localparam logic [7:0] CNT_ONE = 8'h01;
   localparam logic PRE_LAST = 1'b1;

   // Generator states.
   typedef enum logic [1:0] {
      SPBRG_IDLE = 2'b00,
      SPBRG_RUN = 2'b01,
      SPBRG_STRETCH = 2'b10
   } spbrg_state_t;

endpackage : spbrg_pkg

`default_nettype wire

/* File: hw/spbrg_top.sv */
`default_nettype none

module spbrg_top (
   // Clock and synchronous reset.
   input wire logic clk,
   input wire logic srst,
   // Register port.
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Serial clock pin, three signals.
   input wire logic sclk_in,
   output logic sclk_out,
   output logic sclk_oe_n,
   // Status toward the shifting logic.
   output logic half_tick,
   output logic busy
);

   // Register file state.
   logic [7:0] reload_r;
   logic [7:0] buffer_r;
   logic [2:0] ctrl_r;
   logic wcol_r;
   logic [7:0] rdata_r;

   // Generator state.
   spbrg_pkg::spbrg_state_t state_r;
   spbrg_pkg::spbrg_state_t state_nxt;
   logic [7:0] cnt_r;
   logic pre_r;
   logic [4:0] half_r;
   logic level_r;
   logic tick_r;

   // Pin synchroniser.
   logic sclk_meta_r;
   logic sclk_sync_r;

   // Decoded strobes and conditions.
   logic wr_reload;
   logic wr_buffer;
   logic wr_ctrl;
   logic wr_status;
   logic enabled;
   logic i2c_mode;
   logic start;
   logic step;
   logic count_end;
   logic last_half;
   logic [4:0] halves;

   // Address decode shared by every register, for writes and reads.
   function automatic logic hit(input logic [2:0] a,
                                input logic [2:0] r);
      hit = (a == r);
   endfunction

   // Address decode for writes.
   always_comb begin
      wr_reload = 1'b0;
      wr_buffer = 1'b0;
      wr_ctrl = 1'b0;
      wr_status = 1'b0;
      if (reg_wr && hit(reg_addr, spbrg_pkg::REG_RELOAD)) begin
         wr_reload = 1'b1;
      end else if (reg_wr && hit(reg_addr, spbrg_pkg::REG_BUFFER)) begin
         wr_buffer = 1'b1;
      end else if (reg_wr && hit(reg_addr, spbrg_pkg::REG_CTRL)) begin
         wr_ctrl = 1'b1;
      end else if (reg_wr && hit(reg_addr, spbrg_pkg::REG_STATUS)) begin
         wr_status = 1'b1;
      end
   end

   assign enabled = ctrl_r[spbrg_pkg::CTRL_EN];
   assign i2c_mode = ctrl_r[spbrg_pkg::CTRL_I2C];

   // A buffer write only starts a transfer while idle and enabled.
   assign start = wr_buffer && enabled &&
                  (state_r == spbrg_pkg::SPBRG_IDLE);

   // The counter steps once per prescaler wrap.
   assign step = (state_r == spbrg_pkg::SPBRG_RUN) &&
                 (pre_r == spbrg_pkg::PRE_LAST);
   assign count_end = step && (cnt_r == spbrg_pkg::ZERO8);

   // An I2C byte carries its acknowledge clock as well.
   assign halves = i2c_mode ? spbrg_pkg::I2C_HALVES :
                              spbrg_pkg::SPI_HALVES;
   assign last_half = (half_r == halves - spbrg_pkg::HALF_ONE);

   // Reload value register; software keeps it away from 0 to 2 in I2C.
   // A new value written mid-run takes effect at the next reload.
   always_ff @(posedge clk) begin
      if (srst) begin
         reload_r <= spbrg_pkg::RELOAD_RST;
      end else if (wr_reload) begin
         reload_r <= reg_wdata;
      end
   end

   // Data buffer; a write while busy is refused and leaves it unchanged.
   always_ff @(posedge clk) begin
      if (srst) begin
         buffer_r <= spbrg_pkg::BUFFER_RST;
      end else if (start) begin
         buffer_r <= reg_wdata;
      end
   end

   // Control register.
   always_ff @(posedge clk) begin
      if (srst) begin
         ctrl_r <= spbrg_pkg::CTRL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= reg_wdata[spbrg_pkg::CTRL_W-1:0];
      end
   end

   // Write collision flag. A fresh collision beats a clear in the
   // same cycle so that no refused write goes unreported.
   always_ff @(posedge clk) begin
      if (srst) begin
         wcol_r <= 1'b0;
      end else if (wr_buffer && !start) begin
         wcol_r <= 1'b1;
      end else if (wr_status && reg_wdata[spbrg_pkg::STAT_WCOL]) begin
         wcol_r <= 1'b0;
      end
   end

   // Read data stand for exactly the cycle after the read strobe.
   always_ff @(posedge clk) begin
      if (srst) begin
         rdata_r <= spbrg_pkg::ZERO8;
      end else if (!reg_rd) begin
         rdata_r <= spbrg_pkg::ZERO8;
      end else if (hit(reg_addr, spbrg_pkg::REG_RELOAD)) begin
         rdata_r <= reload_r;
      end else if (hit(reg_addr, spbrg_pkg::REG_BUFFER)) begin
         rdata_r <= buffer_r;
      end else if (hit(reg_addr, spbrg_pkg::REG_CTRL)) begin
         rdata_r <= {5'h00, ctrl_r};
      end else if (hit(reg_addr, spbrg_pkg::REG_STATUS)) begin
         rdata_r <= {5'h00, wcol_r, level_r,
                     state_r != spbrg_pkg::SPBRG_IDLE};
      end else if (hit(reg_addr, spbrg_pkg::REG_COUNT)) begin
         rdata_r <= cnt_r;
      end else begin
         rdata_r <= spbrg_pkg::ZERO8;
      end
   end

   // Two flip-flops bring the pin level into the clock domain.
   // Only the second stage is read; the first may go metastable when
   // a slave lets the line rise close to a clock edge.
   always_ff @(posedge clk) begin
      if (srst) begin
         sclk_meta_r <= 1'b1;
         sclk_sync_r <= 1'b1;
      end else begin
         sclk_meta_r <= sclk_in;
         sclk_sync_r <= sclk_meta_r;
      end
   end

   // Next state. In I2C a released clock high half only starts its
   // countdown once the pin is seen high, so a slave may stretch it.
   // Disabling the port stops a run at once and leaves the level alone.
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         spbrg_pkg::SPBRG_IDLE: begin
            if (start) begin
               state_nxt = spbrg_pkg::SPBRG_RUN;
            end
         end
         spbrg_pkg::SPBRG_RUN: begin
            if (!enabled) begin
               state_nxt = spbrg_pkg::SPBRG_IDLE;
            end else if (count_end && last_half) begin
               state_nxt = spbrg_pkg::SPBRG_IDLE;
            end else if (count_end && i2c_mode && !level_r) begin
               state_nxt = spbrg_pkg::SPBRG_STRETCH;
            end
         end
         spbrg_pkg::SPBRG_STRETCH: begin
            if (!enabled) begin
               state_nxt = spbrg_pkg::SPBRG_IDLE;
            end else if (sclk_sync_r) begin
               state_nxt = spbrg_pkg::SPBRG_RUN;
            end
         end
         default: begin
            state_nxt = spbrg_pkg::SPBRG_IDLE;
         end
      endcase
   end

   // State register.
   always_ff @(posedge clk) begin
      if (srst) begin
         state_r <= spbrg_pkg::SPBRG_IDLE;
      end else begin
         state_r <= state_nxt;
      end
   end

   // Prescaler: restarts on every load so a half period is exact.
   // Two clocks per count step give four per step over both halves.
   always_ff @(posedge clk) begin
      if (srst) begin
         pre_r <= 1'b0;
      end else if (state_r != spbrg_pkg::SPBRG_RUN ||
                   count_end) begin
         pre_r <= 1'b0;
      end else begin
         pre_r <= ~pre_r;
      end
   end

   // Down-counter. It loads on start, on each end of count that
   // continues in either mode, and when a stretched I2C clock is seen high.
   // A stopped counter keeps its value, which the count register shows.
   always_ff @(posedge clk) begin
      if (srst) begin
         cnt_r <= spbrg_pkg::ZERO8;
      end else if (start) begin
         cnt_r <= reload_r;
      end else if (state_r == spbrg_pkg::SPBRG_STRETCH &&
                   sclk_sync_r) begin
         cnt_r <= reload_r;
      end else if (count_end && !last_half) begin
         cnt_r <= reload_r;
      end else if (step && !count_end) begin
         cnt_r <= cnt_r - spbrg_pkg::CNT_ONE;
      end
   end

   // Half period counter of the current operation.
   // It counts completed halves, so the run ends on its last one.
   always_ff @(posedge clk) begin
      if (srst) begin
         half_r <= spbrg_pkg::HALF_RST;
      end else if (start) begin
         half_r <= spbrg_pkg::HALF_RST;
      end else if (count_end) begin
         half_r <= half_r + spbrg_pkg::HALF_ONE;
      end
   end

   // Clock level. It toggles at every end of count and is never forced
   // at the end, so the pin stays where the last half left it.
   always_ff @(posedge clk) begin
      if (srst) begin
         level_r <= 1'b0;
      end else if (start) begin
         level_r <= i2c_mode ? 1'b0 :
                    ctrl_r[spbrg_pkg::CTRL_IDLE_HI];
      end else if (count_end) begin
         level_r <= ~level_r;
      end
   end

   // One-cycle mark of each half period end for the shift logic.
   always_ff @(posedge clk) begin
      if (srst) begin
         tick_r <= 1'b0;
      end else begin
         tick_r <= count_end;
      end
   end

   // Pin drive. SPI drives both levels; I2C is open drain and only
   // pulls low, which is why the high half waits on the pin itself.
   // The pin value is the clock level in both modes. In I2C the driver
   // is enabled only while the level is low, so a high is never driven
   // onto the shared line. An I2C port left idle after an SPI run that
   // ended high keeps the line released until the next start.
   assign sclk_out = level_r;
   assign sclk_oe_n = i2c_mode ? level_r : 1'b0;

   // Outputs. Busy is decoded from the state register, not a flop.
   assign reg_rdata = rdata_r;
   assign half_tick = tick_r;
   assign busy = (state_r != spbrg_pkg::SPBRG_IDLE);

endmodule : spbrg_top

`default_nettype wire

/* File: dv/spbrg_chk_sva.sv */
`default_nettype none

// Port-level watcher of the generator; ctrl and reload are shadowed here.
module spbrg_chk (
   // Clock and reset.
   input wire logic clk,
   input wire logic srst,
   // Register port.
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   // Pin and status.
   input wire logic sclk_in,
   input wire logic sclk_out,
   input wire logic sclk_oe_n,
   input wire logic half_tick,
   input wire logic busy
);
   timeunit 1ns;
   timeprecision 1ps;
   logic en_r, i2c_r, start;
   logic [7:0] rl_r;
   logic [9:0] gap_r;
   logic [4:0] nt_r;
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // A start is a buffer write while idle and enabled.
   assign start = reg_wr && reg_addr == spbrg_pkg::REG_BUFFER && !busy && en_r;
   // Shadow copies, so timing can be predicted without the bodies.
   always_ff @(posedge clk) begin
      if (srst) begin
         en_r <= 1'b0;
         i2c_r <= 1'b0;
         rl_r <= 8'h00;
      end else if (reg_wr && reg_addr == spbrg_pkg::REG_CTRL) begin
         en_r <= reg_wdata[0];
         i2c_r <= reg_wdata[1];
      end else if (reg_wr && reg_addr == spbrg_pkg::REG_RELOAD) begin
         rl_r <= reg_wdata;
      end
   end
   // Cycles since the last tick, and ticks since the start.
   always_ff @(posedge clk) begin
      gap_r <= start ? 10'h000 : half_tick ? 10'h001 : gap_r + 10'h001;
      nt_r <= start ? 5'h00 : half_tick ? nt_r + 5'h01 : nt_r;
   end
   chk_start_busy: assert property (start |=> busy)
      else $error("start did not raise busy");
   chk_tick_single: assert property (half_tick |=> !half_tick)
      else $error("tick longer than one cycle");
   chk_half_len: assert property (half_tick && !i2c_r |->
      gap_r == 10'(2 * (rl_r + 1))) else $error("half period wrong");
   chk_op_halves: assert property ($fell(busy) && en_r |=> nt_r ==
      (i2c_r ? spbrg_pkg::I2C_HALVES : spbrg_pkg::SPI_HALVES))
      else $error("wrong number of half periods");
   chk_idle_quiet: assert property (!busy && $past(!busy) |->
      !half_tick) else $error("tick while stopped");
   chk_pin_held: assert property (!busy && $past(!busy) &&
      !$past(reg_wr) |-> $stable(sclk_oe_n) && $stable(sclk_out))
      else $error("pin moved idle");
   chk_spi_drive: assert property (!i2c_r && $past(!i2c_r) |->
      !sclk_oe_n) else $error("spi pin drive wrong");
   chk_i2c_low: assert property (i2c_r && !sclk_oe_n |->
      !sclk_out) else $error("i2c pin driven high");
   chk_tick_edge: assert property (half_tick |->
      $changed(sclk_out)) else $error("no clock edge at tick");
   chk_reload_read: assert property ($past(reg_rd) &&
      $past(reg_addr) == spbrg_pkg::REG_RELOAD |-> reg_rdata == $past(rl_r))
      else $error("reload readback wrong");
endmodule // spbrg_chk

bind spbrg_top spbrg_chk i_spbrg_chk (.clk(clk), .srst(srst),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sclk_in(sclk_in),
   .sclk_out(sclk_out), .sclk_oe_n(sclk_oe_n), .half_tick(half_tick),
   .busy(busy));

`default_nettype wire

/* File: dv/spbrg_slave.sv */
`default_nettype none

// Bus slave on the clock line: pull-up plus optional clock stretching.
module spbrg_slave (
   // Clock and master drive.
   input wire logic clk,
   input wire logic sclk_out,
   input wire logic sclk_oe_n,
   // Cycles to hold the line low after each release.
   input wire logic [3:0] stretch,
   // Resolved line level.
   output logic pin
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] hold_r = 4'h0;
   logic oe_n_q = 1'b0;
   // A slave that is not ready keeps the line low after release.
   always_ff @(posedge clk) begin
      oe_n_q <= sclk_oe_n;
      if (sclk_oe_n && !oe_n_q) hold_r <= stretch;
      else if (hold_r != 4'h0) hold_r <= hold_r - 4'h1;
   end
   // The release cycle is held too, so no one-cycle high glitch leaks.
   assign pin = !sclk_oe_n ? sclk_out :
      (hold_r == 4'h0 && !(!oe_n_q && stretch != 4'h0));
endmodule // spbrg_slave

`default_nettype wire

/* File: dv/tb.sv */
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] reg_rdata;
   logic sclk_out, sclk_oe_n, half_tick, busy, pin;
   logic [3:0] stretch = 4'h0;
   int err_count = 0;
   int tests_run = 0;
   int cyc = 0;
   always #12.5 clk = ~clk;
   spbrg_top i_spbrg_top (.clk(clk), .srst(srst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .sclk_in(pin), .sclk_out(sclk_out),
      .sclk_oe_n(sclk_oe_n), .half_tick(half_tick), .busy(busy));
   spbrg_slave i_spbrg_slave (.clk(clk), .sclk_out(sclk_out),
      .sclk_oe_n(sclk_oe_n), .stretch(stretch), .pin(pin));
   task automatic wrap_up();
      if (err_count == 0 && tests_run > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // A hung wait ends the run here rather than stalling forever.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         err_count++;
         wrap_up();
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   // One operation: count ticks until busy drops, time first to last.
   task automatic run(input logic [7:0] r, input int halves, input bit i2c);
      int n, first, last;
      n = 0;
      first = 0;
      last = 0;
      wr(spbrg_pkg::REG_RELOAD, r);
      wr(spbrg_pkg::REG_BUFFER, 8'h5a);
      #1 chk({7'h00, busy}, 8'h01);
      repeat (2000) begin
         if (half_tick === 1'b1) begin
            if (n == 0) first = cyc;
            last = cyc;
            n++;
         end
         if (busy !== 1'b1) break;
         @(posedge clk);
         #1;
      end
      chk({7'h00, busy}, 8'h00);
      chk(8'(n), 8'(halves));
      if (!i2c) chk(8'(last - first), 8'((halves - 1) * 2 * (r + 1)));
   endtask
   initial begin
      repeat (6) @(posedge clk);
      srst <= 1'b0;
      rd(spbrg_pkg::REG_STATUS, 8'h00);
      rd(spbrg_pkg::REG_RELOAD, spbrg_pkg::RELOAD_RST);
      rd(3'h5, 8'h00);
      // Disabled port refuses the start and flags the collision.
      wr(spbrg_pkg::REG_BUFFER, 8'h11);
      rd(spbrg_pkg::REG_STATUS, 8'h04);
      wr(spbrg_pkg::REG_STATUS, 8'h04);
      wr(spbrg_pkg::REG_RELOAD, 8'ha5);
      rd(spbrg_pkg::REG_RELOAD, 8'ha5);
      wr(spbrg_pkg::REG_CTRL, 8'h01);
      run(8'h00, 16, 1'b0);
      run(8'h03, 16, 1'b0);
      rd(spbrg_pkg::REG_STATUS, 8'h00);
      wr(spbrg_pkg::REG_CTRL, 8'h05);
      run(8'h02, 16, 1'b0);
      rd(spbrg_pkg::REG_STATUS, 8'h02);
      // A buffer write mid-run is refused; disabling stops the count.
      wr(spbrg_pkg::REG_CTRL, 8'h01);
      wr(spbrg_pkg::REG_RELOAD, 8'h20);
      wr(spbrg_pkg::REG_BUFFER, 8'h3c);
      wr(spbrg_pkg::REG_BUFFER, 8'hc3);
      wr(spbrg_pkg::REG_CTRL, 8'h00);
      rd(spbrg_pkg::REG_COUNT, 8'h1e);
      rd(spbrg_pkg::REG_STATUS, 8'h04);
      rd(spbrg_pkg::REG_BUFFER, 8'h3c);
      wr(spbrg_pkg::REG_STATUS, 8'h04);
      // I2C with a slow slave; reload kept above two.
      wr(spbrg_pkg::REG_CTRL, 8'h03);
      stretch <= 4'h5;
      run(8'h03, 18, 1'b1);
      rd(spbrg_pkg::REG_STATUS, 8'h00);
      wrap_up();
   end
endmodule // tb

`default_nettype wire
